// >>> rtl/wcs_defines.svh
/*
  constants of the word clock sync control: register offsets, field positions,
  reset values, sample rates and cycle counts at the 125 MHz system clock.
  assumes inclusion by the control module only.
*/
`ifndef WCS_DEFINES_SVH
`define WCS_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define WCS_OFS_CTRL 8'h00
`define WCS_OFS_STATUS 8'h04
`define WCS_OFS_IRQ_STAT 8'h08
`define WCS_OFS_IRQ_MASK 8'h0c
`define WCS_RESP_OKAY 2'h0
`define WCS_RESP_SLVERR 2'h2

// ****************************************
// fields
// ****************************************
`define WCS_CTRL_AUTO_BIT 0
`define WCS_CTRL_PREF_BIT 1
`define WCS_CTRL_BASE_BIT 2
`define WCS_CTRL_RATE_LSB 4
`define WCS_ST_VALID_BIT 0
`define WCS_ST_SLAVE_BIT 1
`define WCS_ST_SPEED_LSB 2
`define WCS_ST_FALLBACK_BIT 4
`define WCS_ST_RATE_LSB 5
`define WCS_ST_PERIOD_LSB 16
`define WCS_IRQ_GAIN_BIT 0
`define WCS_IRQ_LOSS_BIT 1
`define WCS_IRQ_FB_BIT 2

// ****************************************
// reset values
// ****************************************
`define WCS_RST_AUTO 1'b0
`define WCS_RST_PREF 1'b0
`define WCS_RST_BASE 1'b0
`define WCS_RST_RATE 3'h2
`define WCS_RST_MASK 3'h0

// ****************************************
// rates and timing
// ****************************************
`define WCS_CLK_HZ 125000000
`define WCS_FS0_HZ 32000
`define WCS_FS1_HZ 44100
`define WCS_FS2_HZ 48000
`define WCS_FS3_HZ 64000
`define WCS_FS4_HZ 88200
`define WCS_FS5_HZ 96000
`define WCS_FS6_HZ 176400
`define WCS_FS7_HZ 192000
`define WCS_SS_MIN_HZ 31000
`define WCS_SS_MAX_HZ 50000
`define WCS_DS_MIN_HZ 62000
`define WCS_DS_MAX_HZ 100000
`define WCS_QS_MIN_HZ 170000
`define WCS_QS_MAX_HZ 200000
`define WCS_SS_MIN_CYC (`WCS_CLK_HZ / `WCS_SS_MAX_HZ)
`define WCS_SS_MAX_CYC (`WCS_CLK_HZ / `WCS_SS_MIN_HZ)
`define WCS_DS_MIN_CYC (`WCS_CLK_HZ / `WCS_DS_MAX_HZ)
`define WCS_DS_MAX_CYC (`WCS_CLK_HZ / `WCS_DS_MIN_HZ)
`define WCS_QS_MIN_CYC (`WCS_CLK_HZ / `WCS_QS_MAX_HZ)
`define WCS_QS_MAX_CYC (`WCS_CLK_HZ / `WCS_QS_MIN_HZ)
`define WCS_TIMEOUT_CYC (`WCS_SS_MAX_CYC + 1)
`define WCS_LOCK_PERIODS 4

`endif

// >>> rtl/wcs_pkg.sv
/*
  types of the word clock sync control.
  assumes nothing of its surroundings.
*/
package wcs_pkg;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    WCS_HUNT = 2'b01,
    WCS_LOCKED = 2'b10
  } wcs_lock_state_t;

  typedef enum logic [1:0] {
    WCS_SPD_NONE = 2'h0,
    WCS_SPD_SINGLE = 2'h1,
    WCS_SPD_DOUBLE = 2'h2,
    WCS_SPD_QUAD = 2'h3
  } wcs_speed_t;

endpackage : wcs_pkg

// >>> rtl/wcs_word_clock_ctrl.sv
/*
  word clock input detection, reference selection and word clock output
  generation with an axi4-lite register slave and one level interrupt.
  assumes word clock input synchronous to clk and a single 125 MHz clock.
*/
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
//
// Functional notes
// - word clock is the reference only if preferred, automatic mode, and signal valid.
// - single, double or quad speed input is accepted and classed automatically.
// - a valid word clock lights the lock indicator and shows lock in status.
// - word clock output runs always, at the current sample frequency.
// - master mode output follows the software requested sample rate.
// - slave mode output equals the frequency at the selected input.
// - on reference loss, switch to master at the nearest standard rate.
// - base-rate option keeps output within 32 to 48 kHz by division.
// - refreshed output is phase locked and in phase with the input.
`timescale 1ns/100ps
`include "wcs_defines.svh"
`default_nettype none

module wcs_word_clock_ctrl #(
  parameter int ADDR_W = 8,
  parameter int PER_W = 13
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wc_in,
  output logic wc_out,
  output logic word_clock_lock_indicator,
  output logic irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int GEN_W = PER_W + 2;
  localparam int STALL_MAX = 4 * `WCS_TIMEOUT_CYC;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (PER_W > 16 || (1 << PER_W) <= `WCS_TIMEOUT_CYC + 1) begin : g_per_chk
    $error("PER_W cannot hold the longest word clock period");
  end
  if (ADDR_W < 4) begin : g_addr_chk
    $error("ADDR_W too small for the register map");
  end

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [2:0] reg_dec(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(`WCS_OFS_CTRL)) reg_dec = 3'h4;
    else if (a == ADDR_W'(`WCS_OFS_STATUS)) reg_dec = 3'h5;
    else if (a == ADDR_W'(`WCS_OFS_IRQ_STAT)) reg_dec = 3'h6;
    else if (a == ADDR_W'(`WCS_OFS_IRQ_MASK)) reg_dec = 3'h7;
    else reg_dec = 3'h0;
  endfunction : reg_dec

  function automatic wcs_pkg::wcs_speed_t classify(input logic [PER_W-1:0] p);
    if (p >= `WCS_SS_MIN_CYC && p <= `WCS_SS_MAX_CYC) classify = wcs_pkg::WCS_SPD_SINGLE;
    else if (p >= `WCS_DS_MIN_CYC && p <= `WCS_DS_MAX_CYC) classify = wcs_pkg::WCS_SPD_DOUBLE;
    else if (p >= `WCS_QS_MIN_CYC && p <= `WCS_QS_MAX_CYC) classify = wcs_pkg::WCS_SPD_QUAD;
    else classify = wcs_pkg::WCS_SPD_NONE;
  endfunction : classify

  function automatic logic [GEN_W-1:0] rate_half(input logic [2:0] idx);
    unique case (idx)
      3'h0: rate_half = GEN_W'(`WCS_CLK_HZ / (2 * `WCS_FS0_HZ));
      3'h1: rate_half = GEN_W'(`WCS_CLK_HZ / (2 * `WCS_FS1_HZ));
      3'h2: rate_half = GEN_W'(`WCS_CLK_HZ / (2 * `WCS_FS2_HZ));
      3'h3: rate_half = GEN_W'(`WCS_CLK_HZ / (2 * `WCS_FS3_HZ));
      3'h4: rate_half = GEN_W'(`WCS_CLK_HZ / (2 * `WCS_FS4_HZ));
      3'h5: rate_half = GEN_W'(`WCS_CLK_HZ / (2 * `WCS_FS5_HZ));
      3'h6: rate_half = GEN_W'(`WCS_CLK_HZ / (2 * `WCS_FS6_HZ));
      3'h7: rate_half = GEN_W'(`WCS_CLK_HZ / (2 * `WCS_FS7_HZ));
    endcase
  endfunction : rate_half

  function automatic logic [2:0] base_idx(input logic [2:0] idx);
    if (idx >= 3'h6) base_idx = idx - 3'h5;
    else if (idx >= 3'h3) base_idx = idx - 3'h3;
    else base_idx = idx;
  endfunction : base_idx

  function automatic logic [2:0] nearest_rate(input logic [PER_W-1:0] p);
    int d;
    int best;
    best = 32'h7fffffff;
    nearest_rate = 3'h2;
    for (int i = 0; i < 8; i++) begin
      d = int'(p) - 2 * int'(rate_half(3'(i)));
      if (d < 0) d = -d;
      if (d < best) begin
        best = d;
        nearest_rate = 3'(i);
      end
    end
  endfunction : nearest_rate

  // ****************************************
  // state
  // ****************************************
  logic wc_in_q_ff;
  logic [PER_W-1:0] cnt_ff;
  logic [PER_W-1:0] period_ff;
  logic [1:0] good_ff;
  wcs_pkg::wcs_lock_state_t state_ff;
  wcs_pkg::wcs_speed_t speed_ff;
  wcs_pkg::wcs_speed_t cls;
  logic auto_ff, pref_ff, base_ff;
  logic [2:0] rate_ff, fb_rate_ff, mask_ff, irq_st_ff, nxt_irq_st;
  logic slave_ff, fb_ff, wc_out_ff, lock_led_ff, irq_ff;
  logic [GEN_W-1:0] gen_ff, half_len;
  logic [1:0] div_ff, div_mask;
  logic [1:0] sh;
  logic [2:0] mrate, erate, wsel, rsel;
  logic in_rise, valid, use_cond, ev_fb, ctrl_wr, wr_fire;
  logic aw_have_ff, w_have_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff, rdata_ff, rd_word;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  assign in_rise = wc_in & ~wc_in_q_ff;
  assign cls = classify(PER_W'(cnt_ff + 1'b1));
  assign valid = (state_ff == wcs_pkg::WCS_LOCKED);
  assign use_cond = auto_ff & pref_ff & valid;
  assign ev_fb = slave_ff & ~valid;

  // ****************************************
  // input period measurement and lock
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      wc_in_q_ff <= 1'b0;
    end else if (ce) begin
      wc_in_q_ff <= wc_in;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff <= '0;
      period_ff <= '0;
      good_ff <= 2'h0;
      state_ff <= wcs_pkg::WCS_HUNT;
      speed_ff <= wcs_pkg::WCS_SPD_NONE;
    end else if (ce) begin
      if (in_rise) begin
        cnt_ff <= '0;
        period_ff <= PER_W'(cnt_ff + 1'b1);
        speed_ff <= cls;
        if (cls == wcs_pkg::WCS_SPD_NONE || (valid && cls != speed_ff)) begin
          state_ff <= wcs_pkg::WCS_HUNT;
          good_ff <= 2'h0;
        end else begin
          if (!valid) begin
            if (good_ff == 2'(`WCS_LOCK_PERIODS - 1)) begin
              state_ff <= wcs_pkg::WCS_LOCKED;
              good_ff <= 2'h0;
            end else begin
              good_ff <= (cls == speed_ff) ? good_ff + 2'h1 : 2'h0;
            end
          end
        end
      end else if (cnt_ff == PER_W'(`WCS_TIMEOUT_CYC)) begin
        state_ff <= wcs_pkg::WCS_HUNT;
        good_ff <= 2'h0;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  // ****************************************
  // reference selection and fallback
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      slave_ff <= 1'b0;
      lock_led_ff <= 1'b0;
      fb_ff <= 1'b0;
      fb_rate_ff <= `WCS_RST_RATE;
    end else if (ce) begin
      slave_ff <= use_cond;
      lock_led_ff <= valid;
      if (ev_fb) begin
        fb_ff <= 1'b1;
        fb_rate_ff <= nearest_rate(period_ff);
      end else if (ctrl_wr) begin
        fb_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // word clock output generator
  // ****************************************
  assign mrate = fb_ff ? fb_rate_ff : rate_ff;
  assign erate = base_ff ? base_idx(mrate) : mrate;
  assign sh = !base_ff ? 2'h0 : (speed_ff == wcs_pkg::WCS_SPD_QUAD) ? 2'h2 :
              (speed_ff == wcs_pkg::WCS_SPD_DOUBLE) ? 2'h1 : 2'h0;
  assign div_mask = (sh == 2'h2) ? 2'h3 : (sh == 2'h1) ? 2'h1 : 2'h0;
  assign half_len = slave_ff ? GEN_W'(({2'b00, period_ff} << sh) >> 1) : rate_half(erate);

  always_ff @(posedge clk) begin
    if (srst) begin
      wc_out_ff <= 1'b0;
      gen_ff <= '0;
      div_ff <= 2'h0;
    end else if (ce) begin
      if (slave_ff) begin
        if (in_rise && (div_ff & div_mask) == 2'h0) begin
          wc_out_ff <= 1'b1;
          gen_ff <= GEN_W'(half_len - 1'b1);
        end else if (gen_ff != '0) begin
          gen_ff <= gen_ff - 1'b1;
        end else begin
          wc_out_ff <= 1'b0;
        end
        if (in_rise) div_ff <= div_ff + 2'h1;
      end else begin
        div_ff <= 2'h0;
        if (gen_ff == '0) begin
          wc_out_ff <= ~wc_out_ff;
          gen_ff <= GEN_W'(half_len - 1'b1);
        end else begin
          gen_ff <= gen_ff - 1'b1;
        end
      end
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  assign wr_fire = aw_have_ff & w_have_ff & ~bvalid_ff;
  assign wsel = reg_dec(aw_addr_ff);
  assign ctrl_wr = wr_fire & (wsel == 3'h4) & w_strb_ff[0];

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= `WCS_RESP_OKAY;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && awready_ff) begin
        aw_addr_ff <= s_axi_awaddr;
        aw_have_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        w_have_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wsel[2] ? `WCS_RESP_OKAY : `WCS_RESP_SLVERR;
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // registers and interrupt
  // ****************************************
  always_comb begin
    nxt_irq_st = irq_st_ff;
    if (wr_fire && wsel == 3'h6 && w_strb_ff[0]) nxt_irq_st = nxt_irq_st & ~w_data_ff[2:0];
    nxt_irq_st[`WCS_IRQ_GAIN_BIT] = nxt_irq_st[`WCS_IRQ_GAIN_BIT] | (valid & ~lock_led_ff);
    nxt_irq_st[`WCS_IRQ_LOSS_BIT] = nxt_irq_st[`WCS_IRQ_LOSS_BIT] | (~valid & lock_led_ff);
    nxt_irq_st[`WCS_IRQ_FB_BIT] = nxt_irq_st[`WCS_IRQ_FB_BIT] | ev_fb;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      auto_ff <= `WCS_RST_AUTO;
      pref_ff <= `WCS_RST_PREF;
      base_ff <= `WCS_RST_BASE;
      rate_ff <= `WCS_RST_RATE;
      mask_ff <= `WCS_RST_MASK;
      irq_st_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      if (ctrl_wr) begin
        auto_ff <= w_data_ff[`WCS_CTRL_AUTO_BIT];
        pref_ff <= w_data_ff[`WCS_CTRL_PREF_BIT];
        base_ff <= w_data_ff[`WCS_CTRL_BASE_BIT];
        rate_ff <= w_data_ff[`WCS_CTRL_RATE_LSB +: 3];
      end
      if (wr_fire && wsel == 3'h7 && w_strb_ff[0]) mask_ff <= w_data_ff[2:0];
      irq_st_ff <= nxt_irq_st;
      irq_ff <= |(nxt_irq_st & mask_ff);
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  assign rsel = reg_dec(s_axi_araddr);

  always_comb begin
    rd_word = 32'h0;
    unique case (rsel)
      3'h4: begin
        rd_word[`WCS_CTRL_AUTO_BIT] = auto_ff;
        rd_word[`WCS_CTRL_PREF_BIT] = pref_ff;
        rd_word[`WCS_CTRL_BASE_BIT] = base_ff;
        rd_word[`WCS_CTRL_RATE_LSB +: 3] = rate_ff;
      end
      3'h5: begin
        rd_word[`WCS_ST_VALID_BIT] = valid;
        rd_word[`WCS_ST_SLAVE_BIT] = slave_ff;
        rd_word[`WCS_ST_SPEED_LSB +: 2] = speed_ff;
        rd_word[`WCS_ST_FALLBACK_BIT] = fb_ff;
        rd_word[`WCS_ST_RATE_LSB +: 3] = erate;
        rd_word[`WCS_ST_PERIOD_LSB +: PER_W] = period_ff;
      end
      3'h6: rd_word[2:0] = irq_st_ff;
      3'h7: rd_word[2:0] = mask_ff;
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `WCS_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_word;
        rresp_ff <= rsel[2] ? `WCS_RESP_OKAY : `WCS_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  assign wc_out = wc_out_ff;
  assign word_clock_lock_indicator = lock_led_ff;
  assign irq = irq_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ****************************************
  // assertions
  // ****************************************
  logic [15:0] stall_ff;
  always_ff @(posedge clk) begin
    if (srst) stall_ff <= 16'h0;
    else if (ce) stall_ff <= (wc_out_ff != $past(wc_out_ff)) ? 16'h0 : stall_ff + 16'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_SYNC_COND: assert property ($rose(slave_ff) |-> $past(auto_ff && pref_ff && valid))
    else $error("slave entered without all three conditions");
  AST_SPEED: assert property (valid |-> speed_ff != wcs_pkg::WCS_SPD_NONE)
    else $error("locked without a speed class");
  AST_LOCK_LED: assert property (ce && valid && !lock_led_ff |=> lock_led_ff)
    else $error("lock indicator not lit after lock");
  AST_OUT_RUNS: assert property (stall_ff <= 16'(STALL_MAX))
    else $error("word clock output stalled");
  AST_MASTER_TOG: assert property (ce && !slave_ff && gen_ff == '0 |=> wc_out_ff != $past(wc_out_ff))
    else $error("master output missed its toggle");
  AST_SLAVE_LEN: assert property (ce && slave_ff && in_rise && div_ff == 2'h0 |=> gen_ff == $past(half_len) - 1'b1)
    else $error("slave high time not set from measured period");
  AST_FALLBACK: assert property (ce && slave_ff && !valid |=> fb_ff && !slave_ff)
    else $error("no fallback to master on loss");
  AST_BASE_RATE: assert property (!slave_ff && base_ff |-> erate <= 3'h2)
    else $error("base-rate output above 48 kHz");
  AST_PHASE: assert property (ce && slave_ff && in_rise && (div_ff & div_mask) == 2'h0 |=> wc_out_ff)
    else $error("output not rising with input edge");
  AST_VALID_RANGE: assert property (valid |-> classify(period_ff) == speed_ff)
    else $error("lock held on out of range period");

  COV_LOCK: cover property ($rose(valid));
  COV_FALLBACK: cover property (ev_fb && ce);
  COV_BASE_QUAD: cover property (slave_ff && base_ff && speed_ff == wcs_pkg::WCS_SPD_QUAD && $rose(wc_out_ff));
  COV_IRQ: cover property ($rose(irq_ff));

endmodule : wcs_word_clock_ctrl

`default_nettype wire

// >>> test/wcs_wc_source.sv
/*
  word clock source model of the far side.
  assumes the bench clock and a period given in clk cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module wcs_wc_source (
  input wire logic clk,
  input wire logic run,
  input wire logic [12:0] per,
  output logic wc
);
  // ****
  // square wave, still and low when off
  // ****
  logic [12:0] cnt_ff;
  always_ff @(posedge clk) begin
    if (!run) begin
      cnt_ff <= 13'h0;
      wc <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff >= per - 13'h1) ? 13'h0 : cnt_ff + 13'h1;
      wc <= (cnt_ff < (per >> 1));
    end
  end
endmodule : wcs_wc_source
`default_nettype wire

// >>> test/word_clock_sync_control_test.sv
/*
  self-checking bench of the word clock sync control.
  assumes the word clock source model and the design files.
*/
`timescale 1ns/100ps
`default_nettype none
module word_clock_sync_control_test;
  logic clk, srst, ce, wc_in, wc_out, lock, irq, run;
  logic [12:0] per;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int errors, compares, seed, h, i;
  int hp[8] = '{1953, 1417, 1302, 976, 708, 651, 354, 325};
  int pq[3] = '{651, 1302, 2604};
  logic [31:0] q_dat[$], q_msk[$];
  logic [1:0] q_rr[$], q_br[$];

  wcs_word_clock_ctrl i_wcs_word_clock_ctrl (.clk(clk), .srst(srst), .ce(ce), .wc_in(wc_in), .wc_out(wc_out),
    .word_clock_lock_indicator(lock), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  wcs_wc_source i_wcs_wc_source (.clk(clk), .run(run), .per(per), .wc(wc_in));

  // ****
  // helpers
  // ****
  task automatic tally_and_finish();
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : check

  task automatic bail();
    errors++;
    tally_and_finish();
  endtask : bail

  function automatic logic sel(input int w);
    return (w == 0) ? lock : (w == 1) ? wc_out : wc_in;
  endfunction : sel

  function automatic logic [31:0] ok(input int n, input int e);
    return {31'h0, (n >= e - 1 && n <= e + 1)};
  endfunction : ok

  task automatic wait_on(input int w, input logic v, input int lim, output int n);
    n = 0;
    while (sel(w) !== v) begin
      @(posedge clk);
      n++;
      if (n > lim) bail();
    end
  endtask : wait_on

  task automatic half(output int n);
    wait_on(1, !wc_out, 5000, n);
    wait_on(1, !wc_out, 5000, n);
  endtask : half

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    q_br.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
      if (n > 100) bail();
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    int n;
    q_dat.push_back(e & m);
    q_msk.push_back(m);
    q_rr.push_back(r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      n++;
      if (n > 100) bail();
    end while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  // ****
  // response monitors
  // ****
  always @(posedge clk) begin
    if (rvalid && rready) begin
      if (q_dat.size() == 0) begin
        check("read_unexpected", 32'h1, 32'h0);
      end else begin
        check("rresp", {30'h0, rresp}, {30'h0, q_rr.pop_front()});
        check("rdata", rdata & q_msk.pop_front(), q_dat.pop_front());
      end
    end
    if (bvalid && bready) begin
      if (q_br.size() == 0) begin
        check("write_unexpected", 32'h1, 32'h0);
      end else begin
        check("bresp", {30'h0, bresp}, {30'h0, q_br.pop_front()});
      end
    end
  end

  // ****
  // clock and main sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    seed = 80;
    errors = 0;
    compares = 0;
    srst = 1'b1;
    ce = 1'b1;
    run = 1'b0;
    per = 13'd2604;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(8'h00, 32'h20, 32'hff, 2'h0);
    rd(8'h04, 32'h40, 32'hff, 2'h0);
    rd(8'h08, 32'h0, 32'h7, 2'h0);
    rd(8'h0c, 32'h0, 32'h7, 2'h0);
    rd(8'h10, 32'h0, 32'hffffffff, 2'h2);
    wr(8'h10, $random(seed), 2'h2);
    wr(8'h04, 32'hff, 2'h0);
    rd(8'h04, 32'h40, 32'hff, 2'h0);
    for (i = 0; i < 8; i++) begin
      wr(8'h00, ($random(seed) & 32'hffffff00) | 32'(i << 4), 2'h0);
      half(h);
      check("master_half", ok(h, hp[i]), 32'h1);
      rd(8'h04, 32'(i << 5), 32'he0, 2'h0);
    end
    wr(8'h00, 32'h74, 2'h0);
    half(h);
    check("base_half", ok(h, 1302), 32'h1);
    rd(8'h04, 32'h40, 32'he0, 2'h0);
    wr(8'h00, 32'h34, 2'h0);
    half(h);
    check("base_half", ok(h, 1953), 32'h1);
    h = $random(seed);
    wr(8'h0c, h, 2'h0);
    rd(8'h0c, h, 32'h7, 2'h0);
    wr(8'h0c, 32'h7, 2'h0);
    wr(8'h00, 32'h21, 2'h0);
    run <= 1'b1;
    for (i = 0; i < 3; i++) begin
      per <= 13'(pq[i]);
      wait_on(0, 1'b0, 5000, h);
      wait_on(0, 1'b1, 20000, h);
      rd(8'h04, 32'h1 | 32'((3 - i) << 2), 32'h1f, 2'h0);
    end
    check("lock", {31'h0, lock}, 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    wr(8'h08, 32'h7, 2'h0);
    rd(8'h08, 32'h0, 32'h7, 2'h0);
    check("irq", {31'h0, irq}, 32'h0);
    per <= 13'd1100;
    wait_on(0, 1'b0, 5000, h);
    repeat (6000) @(posedge clk);
    check("lock", {31'h0, lock}, 32'h0);
    rd(8'h04, 32'h0, 32'h0f, 2'h0);
    per <= 13'd2834;
    wr(8'h00, 32'h23, 2'h0);
    wait_on(0, 1'b1, 20000, h);
    rd(8'h04, 32'h3, 32'h3, 2'h0);
    wait_on(2, 1'b0, 5000, h);
    h = 0;
    do begin
      @(posedge clk);
      #1;
      h++;
      if (h > 5000) bail();
    end while (wc_in !== 1'b1);
    check("phase_pre", {31'h0, wc_out}, 32'h0);
    @(posedge clk);
    #1;
    check("phase_post", {31'h0, wc_out}, 32'h1);
    half(h);
    check("slave_half", ok(h, 1417), 32'h1);
    wr(8'h08, 32'h7, 2'h0);
    wr(8'h0c, 32'h4, 2'h0);
    run <= 1'b0;
    wait_on(0, 1'b0, 5000, h);
    repeat (4) @(posedge clk);
    rd(8'h04, 32'h30, 32'hf3, 2'h0);
    rd(8'h08, 32'h6, 32'h6, 2'h0);
    check("irq", {31'h0, irq}, 32'h1);
    half(h);
    check("fallback_half", ok(h, 1417), 32'h1);
    wr(8'h0c, 32'h0, 2'h0);
    repeat (2) @(posedge clk);
    check("irq_masked", {31'h0, irq}, 32'h0);
    wr(8'h08, 32'h6, 2'h0);
    wr(8'h00, 32'h20, 2'h0);
    rd(8'h04, 32'h40, 32'hf3, 2'h0);
    wait_on(1, !wc_out, 5000, h);
    ce <= 1'b0;
    repeat (100) @(posedge clk);
    ce <= 1'b1;
    wait_on(1, !wc_out, 5000, h);
    check("ce_hold_half", ok(h, 1302), 32'h1);
    tally_and_finish();
  end
endmodule : word_clock_sync_control_test
`default_nettype wire
